// [rtl/vcsp_defs.svh]
`ifndef VCSP_DEFS_SVH
`define VCSP_DEFS_SVH
`define VCSP_ADDR_TXDATA 32'h0000_0000
`define VCSP_ADDR_RXDATA 32'h0000_0004
`define VCSP_ADDR_STATUS 32'h0000_0008
`define VCSP_ADDR_CTRL 32'h0000_000c
`define VCSP_RESP_OKAY 2'h0
`define VCSP_RESP_SLVERR 2'h2
`define VCSP_LEN_COMP 5'h08
`define VCSP_LEN_LIN 5'h10
`define VCSP_FIFO_WIDTH 16
`define VCSP_FIFO_DEPTH 32
`define VCSP_CLK_NS 8
`define VCSP_CLK_MHZ 125
`define VCSP_FRAME_US 125
`define VCSP_FRAME_CYC (`VCSP_FRAME_US * `VCSP_CLK_MHZ)
`define VCSP_MAX_FS_KHZ 16
`define VCSP_MCLK_KHZ 2048
`define VCSP_STBY_FRAMES 5
`define VCSP_STRAP_NS 2560
`define VCSP_STRAP_CYC ((`VCSP_STRAP_NS + `VCSP_CLK_NS - 1) / `VCSP_CLK_NS)
`define VCSP_CTRL_EN_BIT 0
`define VCSP_CTRL_CLR_BIT 1
`define VCSP_CTRL_RST 1'b0
`endif

// [rtl/vcsp_pkg.sv]
package vcsp_pkg;
    typedef enum logic [1:0] {
        VCSP_TX_IDLE = 2'b01,
        VCSP_TX_SHIFT = 2'b10
    } vcsp_tx_e;
    typedef logic [15:0] vcsp_word_t;
endpackage : vcsp_pkg

// [rtl/vcsp_core.sv]
// Summary of operation
// - companded words are exactly eight bits
// - linear words: 13 sample bits, three extra
// - linear receive extra bits set volume
// - companded transmit compresses, linear sends raw
// - companded receive expands, linear taken raw
// - fixed rate: master clock is bit clock
// - variable rate: separate data clocks time bits
// - receive clock tied high selects fixed rate
// - receive bits sampled on falling clock edges
// - transmit bits driven on rising clock edges
// - frame rates up to 16 kHz
// - coding select low linear, high companded
// - five idle frames: standby, high: test
// - fixed rate: slot strobe open drain low
`include "vcsp_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module vcsp_fifo #(
    parameter int WIDTH = `VCSP_FIFO_WIDTH,
    parameter int DEPTH = `VCSP_FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_r != '0);
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    assign rd_data = mem_r[rp_r];

    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem_r[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= AW'(wp_r + 1'b1);
            end
            if (pop)
            begin
                rp_r <= AW'(rp_r + 1'b1);
            end
            cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : vcsp_fifo

module vcsp_core #(
    parameter int FRAME_CYC = `VCSP_FRAME_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_clock,
    input wire logic rx_bit_clock,
    input wire logic tx_bit_clock,
    output logic tx_slot_strobe,
    output logic tx_slot_strobe_oe,
    input wire logic rx_frame_sync,
    input wire logic tx_frame_sync,
    input wire logic rx_serial_data,
    output logic tx_serial_data,
    output logic tx_serial_data_oe,
    input wire logic coding_select,
    output logic [2:0] rx_volume
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NP = 7;
    localparam int P_MCLK = 0;
    localparam int P_RXC = 1;
    localparam int P_TXC = 2;
    localparam int P_FSR = 3;
    localparam int P_FSX = 4;
    localparam int P_DIN = 5;
    localparam int P_CODE = 6;
    localparam logic [23:0] STBY_LIM = 24'(FRAME_CYC * `VCSP_STBY_FRAMES - 1);
    localparam logic [9:0] STRAP_LIM = 10'(`VCSP_STRAP_CYC - 1);
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] f_r;
    logic [NP-1:0] rise_r;
    logic [NP-1:0] fall_r;
    assign pin_raw = {coding_select, rx_serial_data, tx_frame_sync, rx_frame_sync,
                      tx_bit_clock, rx_bit_clock, master_clock};

    for (genvar i = 0; i < NP; i++)
    begin : g_sync
        logic [2:0] s_r;
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                s_r <= 3'h0;
                f_r[i] <= 1'b0;
                rise_r[i] <= 1'b0;
                fall_r[i] <= 1'b0;
            end
            else
            begin
                s_r <= {s_r[1:0], pin_raw[i]};
                // a level counts only once two stages agree
                rise_r[i] <= (s_r[1] == s_r[2]) && s_r[2] && !f_r[i];
                fall_r[i] <= (s_r[1] == s_r[2]) && !s_r[2] && f_r[i];
                if (s_r[1] == s_r[2])
                begin
                    f_r[i] <= s_r[2];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // mode strap and bit clock selection
    // ------------------------------------------------------------
    logic fixed_r;
    logic [9:0] strap_cnt_r;
    logic comp;
    logic [4:0] word_len;
    logic rx_edge;
    logic tx_edge;
    assign comp = f_r[P_CODE];
    assign word_len = comp ? `VCSP_LEN_COMP : `VCSP_LEN_LIN;
    assign rx_edge = fixed_r ? fall_r[P_MCLK] : fall_r[P_RXC];
    assign tx_edge = fixed_r ? rise_r[P_MCLK] : rise_r[P_TXC];

    // a running receive clock never stays high this long, a tied pin does
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_cnt_r <= 10'h000;
            fixed_r <= 1'b0;
        end
        else if (!f_r[P_RXC])
        begin
            strap_cnt_r <= 10'h000;
            fixed_r <= 1'b0;
        end
        else if (strap_cnt_r == STRAP_LIM)
        begin
            fixed_r <= 1'b1;
        end
        else
        begin
            strap_cnt_r <= 10'(strap_cnt_r + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // companding
    // ------------------------------------------------------------
    function automatic logic [7:0] vcsp_compress(input logic [12:0] s);
        logic [11:0] mag;
        logic [2:0] seg;
        logic [3:0] man;
        mag = s[12] ? 12'(~s[11:0] + 12'h001) : s[11:0];
        if (s == 13'h1000)
        begin
            mag = 12'hfff;
        end
        seg = 3'h0;
        for (int i = 1; i < 8; i++)
        begin
            if (mag[i+4])
            begin
                seg = 3'(i);
            end
        end
        man = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
        return {s[12], seg, man};
    endfunction : vcsp_compress

    function automatic logic [12:0] vcsp_expand(input logic [7:0] c);
        logic [11:0] mag;
        mag = (c[6:4] == 3'h0) ? {7'h00, c[3:0], 1'b1} : 12'({8'h01, c[3:0]} << c[6:4]);
        return c[7] ? 13'(-{1'b0, mag}) : {1'b0, mag};
    endfunction : vcsp_expand

    // ------------------------------------------------------------
    // receive shifter and fifo
    // ------------------------------------------------------------
    logic rx_busy_r;
    logic [4:0] rx_cnt_r;
    logic [15:0] rx_sh_r;
    logic [15:0] rx_word;
    logic rx_take;
    logic rx_push;
    logic ovf_r;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    vcsp_pkg::vcsp_word_t fifo_wr_data;
    vcsp_pkg::vcsp_word_t fifo_rd_data;
    logic clr_flags;
    assign rx_word = {rx_sh_r[14:0], f_r[P_DIN]};
    assign rx_take = rx_edge && (rx_busy_r || f_r[P_FSR]);
    assign rx_push = rx_take && (rx_cnt_r == 5'(word_len - 1'b1));
    assign fifo_wr_data = comp ? {vcsp_expand(rx_word[7:0]), 3'h0} : rx_word;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 5'h00;
            rx_sh_r <= 16'h0000;
            rx_volume <= 3'h0;
        end
        else if (rx_take)
        begin
            rx_sh_r <= rx_word;
            rx_busy_r <= !rx_push;
            rx_cnt_r <= rx_push ? 5'h00 : 5'(rx_cnt_r + 1'b1);
            if (rx_push && !comp)
            begin
                rx_volume <= rx_word[2:0];
            end
        end
    end

    // the link cannot be stalled, so a full fifo drops the word and flags it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ovf_r <= 1'b0;
        end
        else if (rx_push && !fifo_wr_ready)
        begin
            ovf_r <= 1'b1;
        end
        else if (clr_flags)
        begin
            ovf_r <= 1'b0;
        end
    end

    vcsp_fifo #(.WIDTH(`VCSP_FIFO_WIDTH), .DEPTH(`VCSP_FIFO_DEPTH)) u_rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_valid(rx_push),
        .wr_ready(fifo_wr_ready),
        .wr_data(fifo_wr_data),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready),
        .rd_data(fifo_rd_data)
    );

    // ------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------
    vcsp_pkg::vcsp_tx_e tx_st_r;
    logic [4:0] tx_cnt_r;
    logic [15:0] tx_sh_r;
    logic [15:0] tx_hold_r;
    logic [15:0] tx_load;
    logic tx_new_r;
    logic udr_r;
    logic en_r;
    logic tx_start;
    logic tx_wr;
    assign tx_load = comp ? {vcsp_compress(tx_hold_r[15:3]), 8'h00} : tx_hold_r;
    assign tx_start = tx_edge && (tx_st_r == vcsp_pkg::VCSP_TX_IDLE) && f_r[P_FSX] && en_r;
    assign tx_slot_strobe = 1'b0;
    assign tx_slot_strobe_oe = fixed_r && tx_serial_data_oe;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_st_r <= vcsp_pkg::VCSP_TX_IDLE;
            tx_cnt_r <= 5'h00;
            tx_sh_r <= 16'h0000;
            tx_serial_data <= 1'b0;
            tx_serial_data_oe <= 1'b0;
        end
        else if (tx_edge)
        begin
            unique case (tx_st_r)
                vcsp_pkg::VCSP_TX_IDLE:
                begin
                    if (tx_start)
                    begin
                        tx_serial_data <= tx_load[15];
                        tx_sh_r <= {tx_load[14:0], 1'b0};
                        tx_serial_data_oe <= 1'b1;
                        tx_cnt_r <= 5'h01;
                        tx_st_r <= vcsp_pkg::VCSP_TX_SHIFT;
                    end
                end
                vcsp_pkg::VCSP_TX_SHIFT:
                begin
                    if (tx_cnt_r == word_len)
                    begin
                        tx_serial_data_oe <= 1'b0;
                        tx_cnt_r <= 5'h00;
                        tx_st_r <= vcsp_pkg::VCSP_TX_IDLE;
                    end
                    else
                    begin
                        tx_serial_data <= tx_sh_r[15];
                        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                        tx_cnt_r <= 5'(tx_cnt_r + 1'b1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_new_r <= 1'b0;
            udr_r <= 1'b0;
        end
        else
        begin
            // a fresh write wins over the load that consumes the old word
            tx_new_r <= tx_wr || (tx_new_r && !tx_start);
            udr_r <= (tx_start && !tx_new_r) || (udr_r && !clr_flags);
        end
    end

    // ------------------------------------------------------------
    // frame sync supervision
    // ------------------------------------------------------------
    logic [23:0] hold_cnt_r [2];
    logic [1:0] stby_r;
    logic [1:0] hi_r;
    for (genvar c = 0; c < 2; c++)
    begin : g_fs
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                hold_cnt_r[c] <= 24'h000000;
                stby_r[c] <= 1'b0;
                hi_r[c] <= 1'b0;
            end
            else if (rise_r[P_FSR+c] || fall_r[P_FSR+c])
            begin
                hold_cnt_r[c] <= 24'h000000;
                stby_r[c] <= 1'b0;
                hi_r[c] <= 1'b0;
            end
            else if (hold_cnt_r[c] != STBY_LIM)
            begin
                hold_cnt_r[c] <= 24'(hold_cnt_r[c] + 1'b1);
            end
            else
            begin
                stby_r[c] <= !f_r[P_FSR+c];
                hi_r[c] <= f_r[P_FSR+c];
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic ar_fire;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign fifo_rd_ready = ar_fire && (s_axi_araddr == `VCSP_ADDR_RXDATA);
    assign tx_wr = wr_fire && (awaddr_r == `VCSP_ADDR_TXDATA);
    assign clr_flags = wr_fire && (awaddr_r == `VCSP_ADDR_CTRL) && wstrb_r[0]
                       && wdata_r[`VCSP_CTRL_CLR_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VCSP_RESP_OKAY;
            tx_hold_r <= 16'h0000;
            en_r <= `VCSP_CTRL_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[31:4] == 28'h0000000 && awaddr_r[1:0] == 2'h0)
                               ? `VCSP_RESP_OKAY : `VCSP_RESP_SLVERR;
                if (tx_wr && wstrb_r[0])
                begin
                    tx_hold_r[7:0] <= wdata_r[7:0];
                end
                if (tx_wr && wstrb_r[1])
                begin
                    tx_hold_r[15:8] <= wdata_r[15:8];
                end
                if (awaddr_r == `VCSP_ADDR_CTRL && wstrb_r[0])
                begin
                    en_r <= wdata_r[`VCSP_CTRL_EN_BIT];
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `VCSP_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `VCSP_RESP_OKAY;
            unique case (s_axi_araddr)
                `VCSP_ADDR_TXDATA: s_axi_rdata <= {16'h0000, tx_hold_r};
                `VCSP_ADDR_RXDATA: s_axi_rdata <= {15'h0000, fifo_rd_valid, fifo_rd_data};
                `VCSP_ADDR_STATUS: s_axi_rdata <= {20'h00000, en_r, rx_volume, fifo_rd_valid,
                    udr_r, ovf_r, |hi_r, stby_r[1], stby_r[0], comp, fixed_r};
                `VCSP_ADDR_CTRL: s_axi_rdata <= {31'h00000000, en_r};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `VCSP_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence seq_tx_start;
        tx_edge && (tx_st_r == vcsp_pkg::VCSP_TX_IDLE) && f_r[P_FSX] && en_r;
    endsequence
    sequence seq_tx_slot;
        tx_serial_data_oe && (tx_st_r == vcsp_pkg::VCSP_TX_SHIFT);
    endsequence
    AST_RX_COMP_LEN: assert property (rx_push && comp |-> rx_cnt_r == 5'h07)
        else $error("companded word not eight bits");
    AST_RX_LIN_LEN: assert property (rx_push && !comp |-> rx_cnt_r == 5'h0f)
        else $error("linear word not sixteen bits");
    AST_VOLUME: assert property (rx_push && !comp |=> rx_volume == $past(rx_word[2:0]))
        else $error("volume not taken from received word");
    AST_FIXED_CLK: assert property (
        fixed_r && fall_r[P_MCLK] && rx_take |=> $changed(rx_cnt_r))
        else $error("fixed rate receive ignored master clock");
    AST_VAR_CLK: assert property (!fixed_r && !fall_r[P_RXC] |=> $stable(rx_cnt_r))
        else $error("variable rate receive moved without its clock");
    AST_STRAP: assert property ($rose(fixed_r) |-> $past(strap_cnt_r) == STRAP_LIM)
        else $error("fixed mode entered early");
    AST_RX_EDGE: assert property ($changed(rx_cnt_r) |-> $past(rx_edge))
        else $error("receive bit counted off a falling edge");
    AST_TX_EDGE: assert property ($changed(tx_serial_data) |-> $past(tx_edge))
        else $error("transmit data changed off a rising edge");
    AST_TX_START: assert property (seq_tx_start |=> seq_tx_slot)
        else $error("transmit slot did not start");
    AST_STBY: assert property ($rose(stby_r[0]) |-> $past(hold_cnt_r[0]) == STBY_LIM)
        else $error("standby entered before five frames");
    AST_STROBE: assert property (seq_tx_slot and fixed_r |-> tx_slot_strobe_oe)
        else $error("slot strobe not driven in fixed mode");
    AST_NO_STROBE: assert property (!fixed_r |-> !tx_slot_strobe_oe)
        else $error("slot strobe driven in variable mode");
    AST_IDLE_HIZ: assert property (
        tx_st_r == vcsp_pkg::VCSP_TX_IDLE |-> !tx_serial_data_oe)
        else $error("transmit data driven outside slot");
endmodule : vcsp_core

`default_nettype wire

// [testbench/vcsp_dsp_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vcsp_dsp_model (
    input wire logic fixed,
    input wire logic tx_serial_data,
    input wire logic tx_serial_data_oe,
    input wire logic tx_slot_strobe,
    input wire logic tx_slot_strobe_oe,
    output logic master_clock,
    output logic rx_bit_clock,
    output logic tx_bit_clock,
    output logic rx_frame_sync,
    output logic tx_frame_sync,
    output logic rx_serial_data
);
    // ------------
    // far end port
    // ------------
    logic mck = 1'b0;
    logic bck = 1'b0;
    initial {rx_frame_sync, tx_frame_sync, rx_serial_data} = 3'h0;
    always #244 if (!fixed) mck = ~mck;
    assign master_clock = mck;
    assign rx_bit_clock = fixed | bck;
    // pulled up when released
    assign tx_bit_clock = fixed ? (tx_slot_strobe_oe ? tx_slot_strobe : 1'b1) : bck;
    // bit clock stands still low outside frames
    task automatic half(input logic v);
        if (fixed)
            mck = v;
        else
            bck = v;
        #80;
    endtask : half
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got,
        output int cnt, output int bad);
        got = 16'h0;
        cnt = 0;
        bad = 0;
        half(1'b0);
        rx_frame_sync = 1'b1;
        tx_frame_sync = 1'b1;
        #80;
        for (int i = n - 1; i >= 0; i--)
        begin
            rx_serial_data = w[i];
            half(1'b1);
            got = {got[14:0], tx_serial_data};
            cnt += int'(tx_serial_data_oe === 1'b1);
            bad += int'(fixed && tx_slot_strobe_oe !== tx_serial_data_oe);
            half(1'b0);
        end
        rx_frame_sync = 1'b0;
        tx_frame_sync = 1'b0;
        rx_serial_data = ~w[0];
        half(1'b1);
        bad += int'(tx_serial_data_oe !== 1'b0);
        half(1'b0);
    endtask : frame
    // syncs parked at one level, no bit clock, to reach standby or test
    task automatic hold(input logic v);
        rx_frame_sync = v;
        tx_frame_sync = v;
    endtask : hold
endmodule : vcsp_dsp_model
`default_nettype wire

// [testbench/tb_vcsp_core.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_vcsp_core;
    // -----
    // bench
    // -----
    localparam int FC = 40;
    logic aclk = 1'b0, aresetn = 1'b0, coding_select = 1'b0, fixed = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic mclk, rxc, txc, rfs, tfs, rxd, txd, txoe, stb, stboe;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [2:0] vol;
    logic [15:0] got;
    int miscompares = 0, compares = 0, cnt, bad;
    vcsp_core #(
        .FRAME_CYC(FC)
    ) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .master_clock(mclk), .rx_bit_clock(rxc), .tx_bit_clock(txc), .tx_slot_strobe(stb),
        .tx_slot_strobe_oe(stboe), .rx_frame_sync(rfs), .tx_frame_sync(tfs),
        .rx_serial_data(rxd), .tx_serial_data(txd), .tx_serial_data_oe(txoe),
        .coding_select(coding_select), .rx_volume(vol)
    );
    vcsp_dsp_model i_dsp (
        .fixed(fixed), .tx_serial_data(txd), .tx_serial_data_oe(txoe), .tx_slot_strobe(stb),
        .tx_slot_strobe_oe(stboe), .master_clock(mclk), .rx_bit_clock(rxc),
        .tx_bit_clock(txc), .rx_frame_sync(rfs), .tx_frame_sync(tfs), .rx_serial_data(rxd)
    );
    initial forever #4 aclk = ~aclk;
    task automatic end_sim;
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // bounded wait, sampled mid-cycle where handshakes are settled
    task automatic step(inout int n);
        @(negedge aclk);
        n++;
        if (n > 3000)
        begin
            miscompares++;
            end_sim();
        end
    endtask : step
    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        logic pa, pw, ta, tw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw)
        begin
            step(n);
            ta = pa && awready === 1'b1;
            tw = pw && wready === 1'b1;
            @(posedge aclk);
            pa = pa && !ta;
            pw = pw && !tw;
            awvalid <= pa;
            wvalid <= pw;
        end
        do
            step(n);
        while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            step(n);
        while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do
            step(n);
        while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'hc, d, r);
        chk(d, 32'h0);
        rd(32'h40, d, r);
        chk(r, 2'h2);
        wr(32'h41, 32'h1, r);
        chk(r, 2'h2);
        repeat (5 * FC + 10) @(posedge aclk);
        rd(32'h8, d, r);
        chk(d & 32'h1f, 32'h0c);
        wr(32'h0, 32'ha5c3, r);
        wr(32'hc, 32'h1, r);
        i_dsp.frame(16'h9e35, 16, got, cnt, bad);
        chk(got, 16'ha5c3);
        chk(cnt, 16);
        chk(bad, 0);
        rd(32'h4, d, r);
        chk(d, 32'h19e35);
        chk(vol, 3'h5);
        rd(32'h8, d, r);
        chk(d[3:2], 2'h0);
        coding_select <= 1'b1;
        wr(32'h0, 32'h1234, r);
        i_dsp.frame(16'h00a7, 8, got, cnt, bad);
        chk(got, 16'h0052);
        chk(cnt, 8);
        chk(bad, 0);
        rd(32'h4, d, r);
        chk(d, 32'h1fd20);
        rd(32'h4, d, r);
        chk(d[16], 1'b0);
        chk(vol, 3'h5);
        rd(32'h8, d, r);
        chk(d[1], 1'b1);
        coding_select <= 1'b0;
        fixed <= 1'b1;
        repeat (400) @(posedge aclk);
        rd(32'h8, d, r);
        chk(d[0], 1'b1);
        wr(32'h0, 32'h3c5a, r);
        i_dsp.frame(16'h4321, 16, got, cnt, bad);
        chk(got, 16'h3c5a);
        chk(bad, 0);
        rd(32'h4, d, r);
        chk(d, 32'h14321);
        chk(vol, 3'h1);
        i_dsp.frame(16'h0000, 16, got, cnt, bad);
        chk(got, 16'h3c5a);
        rd(32'h8, d, r);
        chk(d[6], 1'b1);
        wr(32'hc, 32'h3, r);
        rd(32'h8, d, r);
        chk(d[6:5], 2'h0);
        i_dsp.hold(1'b1);
        repeat (5 * FC + 10) @(posedge aclk);
        rd(32'h8, d, r);
        chk(d[4:2], 3'h4);
        end_sim();
    end
endmodule : tb_vcsp_core
`default_nettype wire
